// [logic/actt_defines.svh]
// constants for the convert and trigger timing block
`ifndef ACTT_DEFINES_SVH
`define ACTT_DEFINES_SVH

// clock period
`define ACTT_CLK_PERIOD_NS 5
// delay of convert timebase behind external sync edge
`define ACTT_EXT_DLY_NS 10
`define ACTT_EXT_DLY_CYC \
  ((`ACTT_EXT_DLY_NS + `ACTT_CLK_PERIOD_NS - 1) / `ACTT_CLK_PERIOD_NS)
// field widths
`define ACTT_DIV_W 16
`define ACTT_POST_W 24
`define ACTT_SEL_W 4
`define ACTT_SRC_W 16
`define ACTT_NOUT 4
`define ACTT_OSEL_W 2
// trigger source index of the software pulse
`define ACTT_SRC_SW 0
// export selector codes
`define ACTT_OSEL_OFF 2'h0
`define ACTT_OSEL_CONV 2'h1
`define ACTT_OSEL_START 2'h2
`define ACTT_OSEL_REF 2'h3
// reset values
`define ACTT_RST_DIV 16'h0000
`define ACTT_RST_POST 24'h000000

`endif

// [logic/actt_pkg.sv]
// types shared by the convert and trigger timing block
`include "actt_defines.svh"
package actt_pkg;

  // acquisition phase of the convert level
  typedef enum logic [1:0] {
    ACTT_IDLE,
    ACTT_ARMED,
    ACTT_RUN,
    ACTT_POST
  } actt_phase_e;

  // static configuration, held stable during an acquisition
  typedef struct packed {
    logic                     ext_convert_mode;
    logic                     ref_enable;
    logic [`ACTT_SEL_W-1:0]   start_sel;
    logic [`ACTT_SEL_W-1:0]   ref_sel;
    logic [`ACTT_DIV_W-1:0]   interval_count;
    logic [`ACTT_POST_W-1:0]  posttrig_count;
  } actt_cfg_s;

  // status seen by software
  typedef struct packed {
    logic armed;
    logic running;
    logic post_counting;
    logic sample_ready;
  } actt_stat_s;

  // terminal export group
  typedef struct packed {
    logic [`ACTT_NOUT-1:0] value;
    logic [`ACTT_NOUT-1:0] oe;
  } actt_term_s;

  // divider state
  typedef struct packed {
    logic [`ACTT_DIV_W-1:0] cnt;
  } actt_div_s;

  // whole state of the main block
  typedef struct packed {
    logic                         ctb_q;
    logic                         stb_q;
    logic [`ACTT_EXT_DLY_CYC:0]   edly;
    logic                         sst;
    logic                         srt;
    logic                         st_int;
    logic                         rt_int;
    logic                         ss_sync;
    logic                         ss_int;
    logic                         si_start;
    logic                         smp_ready;
    actt_phase_e                  phase;
    logic [`ACTT_POST_W-1:0]      post_cnt;
    logic                         conv;
    logic                         done;
    actt_term_s                   term;
  } actt_state_s;

endpackage

// [logic/actt_divider.sv]
// convert interval divider: one strobe per n timebase ticks
`include "actt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module actt_divider (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    en,
  input  wire logic                    tick,
  input  wire logic [`ACTT_DIV_W-1:0]  interval_count,
  output logic                         tc
);
  actt_pkg::actt_div_s s_ff;     // current state
  actt_pkg::actt_div_s nxt_s_ff; // next state
  logic [`ACTT_DIV_W-1:0] reload; // count minus one, zero treated as one

  // reload value
  always_comb begin
    if (interval_count == `ACTT_RST_DIV) begin
      reload = `ACTT_RST_DIV;
    end else begin
      reload = interval_count - `ACTT_DIV_W'(1);
    end
  end

  // terminal count strobe, same cycle as the tick
  assign tc = en & tick & (s_ff.cnt == `ACTT_RST_DIV);

  // count down on ticks, reload when idle or at terminal count
  always_comb begin
    nxt_s_ff = s_ff;
    if (!en) begin
      nxt_s_ff.cnt = reload;
    end else if (tick) begin
      if (s_ff.cnt == `ACTT_RST_DIV) begin
        nxt_s_ff.cnt = reload;
      end else begin
        nxt_s_ff.cnt = s_ff.cnt - `ACTT_DIV_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_ff.cnt <= `ACTT_RST_DIV;
    end else begin
      s_ff <= nxt_s_ff;
    end
  end
endmodule
`default_nettype wire

// [logic/actt_convert_trigger.sv]
// convert clock generation and start/reference trigger timing
// Functional notes
// - each conversion starts on a convert clock pulse
// - convert clock comes only from convert timebase
// - external mode: timebase irregular, sync asynchronously related
// - divided mode: sync timebase is inverted timebase
// - external mode: sync is signal, timebase delayed
// - convert clock can drive several output terminals
// - divided mode: divider after timebase; external mode: timebase drives convert clock directly
// - start trigger chosen by source multiplexer
// - start trigger synchronised in both timing levels
// - conversions begin at first sample clock after start
// - sample level ready after accepting start trigger
// - start captured on sync convert timebase edge
// - sample counter start from sample-level sync
// - synchronised start trigger can be exported
// - reference trigger starts posttrigger count, then stop
// - reference trigger chosen by source multiplexer
// - reference trigger synchronised on sync convert timebase
// - synchronised reference trigger can be exported
`include "actt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module actt_convert_trigger #(
  parameter int NOUT = `ACTT_NOUT
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire actt_pkg::actt_cfg_s        cfg,
  input  wire logic [`ACTT_SRC_W-1:1]     trig_sources,
  input  wire logic                       sw_start_pulse,
  input  wire logic                       sw_ref_pulse,
  input  wire logic                       conv_timebase,
  input  wire logic                       sample_timebase,
  input  wire logic                       sample_clock,
  input  wire logic [NOUT*`ACTT_OSEL_W-1:0] out_sel,
  output logic                            converter_start_pulse,
  output logic                            start_trigger,
  output logic                            ref_trigger,
  output logic                            sample_counter_start,
  output logic                            acq_done,
  output actt_pkg::actt_stat_s            status,
  output actt_pkg::actt_term_s            exported_output_terminal
);
  localparam int DLY = `ACTT_EXT_DLY_CYC; // delay line depth

  actt_pkg::actt_state_s s_ff;     // registered state
  actt_pkg::actt_state_s nxt_s_ff; // next state

  logic [`ACTT_SRC_W-1:0] start_src; // start source vector
  logic [`ACTT_SRC_W-1:0] ref_src;   // reference source vector
  logic sel_start;   // selected start trigger
  logic sel_ref;     // selected reference trigger
  logic ctb_rise;    // rising edge of timebase input
  logic ctb_fall;    // falling edge of timebase input
  logic sync_edge;   // sync convert timebase edge
  logic ctb_tick;    // convert timebase edge
  logic stb_rise;    // sample timebase edge
  logic stb_fall;    // sync sample timebase edge
  logic div_en;      // divider runs while converting
  logic div_tc;      // divided timebase strobe
  logic conv_src;    // convert clock before gating
  logic start_evt;   // start accepted in convert level
  logic ref_evt;     // reference accepted in convert level
  logic conv_fire;   // conversion issued this cycle

  // pick one bit of a source vector by its selector
  function automatic logic pick_src(
    input logic [`ACTT_SRC_W-1:0] v,
    input logic [`ACTT_SEL_W-1:0] sel
  );
    pick_src = v[sel];
  endfunction

  // does the export selector name this signal
  function automatic logic osel_is(
    input logic [`ACTT_OSEL_W-1:0] sel,
    input logic [`ACTT_OSEL_W-1:0] code
  );
    osel_is = (sel == code);
  endfunction

  // source multiplexers, software pulse at index zero
  assign start_src = {trig_sources, sw_start_pulse};
  assign ref_src   = {trig_sources, sw_ref_pulse};
  assign sel_start = pick_src(start_src, cfg.start_sel);
  assign sel_ref   = pick_src(ref_src, cfg.ref_sel);

  // timebase edges from the previous sample
  assign ctb_rise = conv_timebase & ~s_ff.ctb_q;
  assign ctb_fall = ~conv_timebase & s_ff.ctb_q;
  assign stb_rise = sample_timebase & ~s_ff.stb_q;
  assign stb_fall = ~sample_timebase & s_ff.stb_q;

  // sync edge: inverted timebase when divided, raw signal otherwise
  always_comb begin
    if (cfg.ext_convert_mode) begin
      sync_edge = ctb_rise;
      ctb_tick  = s_ff.edly[DLY];
    end else begin
      sync_edge = ctb_fall;
      ctb_tick  = ctb_rise;
    end
  end

  // interval divider only counts while converting
  assign div_en = (s_ff.phase == actt_pkg::ACTT_RUN) |
                  (s_ff.phase == actt_pkg::ACTT_POST);

  // divides the convert timebase in internal mode
  actt_divider u_div (
    .clk            (clk),
    .srst           (srst),
    .en             (div_en),
    .tick           (ctb_tick),
    .interval_count (cfg.interval_count),
    .tc             (div_tc)
  );

  // only the timebase feeds the convert clock
  assign conv_src = cfg.ext_convert_mode ?
                    (ctb_tick & div_en) : div_tc;

  // start and reference accepted on a timebase edge
  assign start_evt = ctb_tick & s_ff.sst & ~s_ff.st_int;
  assign ref_evt   = ctb_tick & s_ff.srt & ~s_ff.rt_int &
                     cfg.ref_enable;

  // main next-state logic
  always_comb begin
    nxt_s_ff = s_ff;
    conv_fire = 1'b0;
    nxt_s_ff.ctb_q = conv_timebase;
    nxt_s_ff.stb_q = sample_timebase;
    nxt_s_ff.done = 1'b0;
    nxt_s_ff.si_start = 1'b0;
    // delay line holds sync edges until the timebase edge
    nxt_s_ff.edly = {s_ff.edly[DLY-1:0], ctb_rise};
    // capture selected triggers on sync convert edge
    if (sync_edge) begin
      nxt_s_ff.sst = sel_start;
      nxt_s_ff.srt = sel_ref;
    end
    // internal triggers follow captured values at timebase edge
    if (ctb_tick) begin
      nxt_s_ff.st_int = s_ff.sst;
      nxt_s_ff.rt_int = s_ff.srt;
    end
    // sample level: own capture on sync sample edge
    if (stb_fall) begin
      nxt_s_ff.ss_sync = sel_start;
    end
    if (stb_rise) begin
      nxt_s_ff.ss_int = s_ff.ss_sync;
      // counter start from sample-level synchronised start
      if (s_ff.ss_sync & ~s_ff.ss_int) begin
        nxt_s_ff.si_start = 1'b1;
        nxt_s_ff.smp_ready = 1'b1;
      end
    end
    // convert level phases
    case (s_ff.phase)
      // wait for start trigger
      actt_pkg::ACTT_IDLE: begin
        if (start_evt) begin
          nxt_s_ff.phase = actt_pkg::ACTT_ARMED;
        end
      end
      // armed: first sample clock starts conversions
      actt_pkg::ACTT_ARMED: begin
        if (sample_clock) begin
          nxt_s_ff.phase = actt_pkg::ACTT_RUN;
        end
      end
      // converting until a reference trigger
      actt_pkg::ACTT_RUN: begin
        conv_fire = conv_src;
        if (ref_evt) begin
          nxt_s_ff.phase = actt_pkg::ACTT_POST;
          nxt_s_ff.post_cnt = cfg.posttrig_count;
        end
      end
      // posttrigger conversions, then stop
      actt_pkg::ACTT_POST: begin
        if (s_ff.post_cnt == `ACTT_RST_POST) begin
          nxt_s_ff.phase = actt_pkg::ACTT_IDLE;
          nxt_s_ff.done = 1'b1;
          nxt_s_ff.smp_ready = 1'b0;
        end else if (conv_src) begin
          conv_fire = 1'b1;
          nxt_s_ff.post_cnt = s_ff.post_cnt -
                              `ACTT_POST_W'(1);
        end
      end
      default: begin
        nxt_s_ff.phase = actt_pkg::ACTT_IDLE;
      end
    endcase
    // one pulse per conversion to the converter
    nxt_s_ff.conv = conv_fire;
    // terminal exports, each with its own selector
    for (int i = 0; i < NOUT; i++) begin
      logic [`ACTT_OSEL_W-1:0] os;
      os = out_sel[i*`ACTT_OSEL_W +: `ACTT_OSEL_W];
      nxt_s_ff.term.oe[i] = ~osel_is(os, `ACTT_OSEL_OFF);
      nxt_s_ff.term.value[i] =
        (osel_is(os, `ACTT_OSEL_CONV) & conv_fire) |
        (osel_is(os, `ACTT_OSEL_START) &
         nxt_s_ff.st_int) |
        (osel_is(os, `ACTT_OSEL_REF) & nxt_s_ff.rt_int);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_ff.ctb_q     <= 1'b0;
      s_ff.stb_q     <= 1'b0;
      s_ff.edly      <= '0;
      s_ff.sst       <= 1'b0;
      s_ff.srt       <= 1'b0;
      s_ff.st_int    <= 1'b0;
      s_ff.rt_int    <= 1'b0;
      s_ff.ss_sync   <= 1'b0;
      s_ff.ss_int    <= 1'b0;
      s_ff.si_start  <= 1'b0;
      s_ff.smp_ready <= 1'b0;
      s_ff.phase     <= actt_pkg::ACTT_IDLE;
      s_ff.post_cnt  <= `ACTT_RST_POST;
      s_ff.conv      <= 1'b0;
      s_ff.done      <= 1'b0;
      s_ff.term      <= '0;
    end else begin
      s_ff <= nxt_s_ff;
    end
  end

  // outputs straight from flip-flops
  assign converter_start_pulse    = s_ff.conv;
  assign start_trigger            = s_ff.st_int;
  assign ref_trigger              = s_ff.rt_int;
  assign sample_counter_start     = s_ff.si_start;
  assign acq_done                 = s_ff.done;
  assign exported_output_terminal = s_ff.term;
  // status view
  assign status.armed         = (s_ff.phase == actt_pkg::ACTT_ARMED);
  assign status.running       = div_en;
  assign status.post_counting = (s_ff.phase == actt_pkg::ACTT_POST);
  assign status.sample_ready  = s_ff.smp_ready;
endmodule
`default_nettype wire

// [verif/actt_assertions.sv]
// checker for the convert and trigger timing block
`include "actt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module actt_assertions #(
  parameter int NOUT = `ACTT_NOUT
) (
  input wire logic                          clk,
  input wire logic                          srst,
  input wire logic [NOUT*`ACTT_OSEL_W-1:0]  out_sel,
  input wire logic                          converter_start_pulse,
  input wire logic                          start_trigger,
  input wire logic                          ref_trigger,
  input wire logic                          sample_counter_start,
  input wire logic                          acq_done,
  input wire actt_pkg::actt_stat_s          status,
  input wire actt_pkg::actt_term_s          exported_output_terminal
);
  logic [NOUT*2-1:0] sel_q;   // selects seen one cycle earlier
  logic [NOUT-1:0]   pick;    // expected terminal values
  logic [NOUT-1:0]   oe_exp;  // expected terminal enables

  // delay the selects to line up with registered exports
  always_ff @(posedge clk) begin
    sel_q <= out_sel;
  end

  // decode what each terminal should show
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      oe_exp[i] = |sel_q[2*i+:2];
      case (sel_q[2*i+:2])
        2'h1: pick[i] = converter_start_pulse;
        2'h2: pick[i] = start_trigger;
        default: pick[i] = ref_trigger;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // done is a lone pulse
  sequence s_done_pulse;
    acq_done ##1 !acq_done;
  endsequence
  // counter start leaves the sample level ready
  sequence s_scs_ready;
    sample_counter_start ##1 status.sample_ready;
  endsequence

  a_conv_one_cycle: assert property (
    converter_start_pulse |=> !converter_start_pulse)
    else $error("convert pulse wider than one cycle");
  a_conv_when_active: assert property (
    converter_start_pulse |-> $past(status.armed || status.running
      || status.post_counting))
    else $error("conversion while idle");
  a_run_after_arm: assert property (
    $rose(status.running) |-> $past(status.armed))
    else $error("running without being armed");
  a_arm_with_start: assert property (
    $rose(status.armed) |-> start_trigger)
    else $error("armed without start trigger");
  a_post_after_run: assert property (
    $rose(status.post_counting) |-> $past(status.running))
    else $error("post count began outside a run");
  a_done_after_post: assert property (
    acq_done |-> $past(status.post_counting))
    else $error("done without post counting");
  a_done_single: assert property (
    acq_done |-> s_done_pulse)
    else $error("done pulse wider than one cycle");
  a_scs_ready: assert property (
    sample_counter_start |-> s_scs_ready)
    else $error("sample level not ready after start");
  a_export_oe: assert property (
    !$past(srst) |-> exported_output_terminal.oe == oe_exp)
    else $error("terminal enable mismatch");
  a_export_value: assert property (
    !$past(srst) |-> (exported_output_terminal.value & oe_exp)
      == (pick & oe_exp))
    else $error("terminal value mismatch");
endmodule

bind actt_convert_trigger actt_assertions #(.NOUT(NOUT)) actt_assertions_i (
  .clk(clk), .srst(srst), .out_sel(out_sel),
  .converter_start_pulse(converter_start_pulse),
  .start_trigger(start_trigger), .ref_trigger(ref_trigger),
  .sample_counter_start(sample_counter_start), .acq_done(acq_done),
  .status(status), .exported_output_terminal(exported_output_terminal));
`default_nettype wire

// [verif/actt_adc_model.sv]
// converter and timebase source model facing the block
`timescale 1ns/1ps
`default_nettype none
module actt_adc_model #(
  parameter int CHALF = 2,  // convert timebase half period
  parameter int SHALF = 3   // sample timebase half period
) (
  input  wire logic         clk,
  input  wire logic         converter_start_pulse,
  output logic              conv_timebase,
  output logic              sample_timebase,
  output logic [15:0]       conv_count,
  output logic [15:0]       conv_gap
);
  int          cc = 0;        // convert timebase phase
  int          sc = 0;        // sample timebase phase
  logic [15:0] since = '0;    // cycles since last conversion
  logic [15:0] n = '0;        // conversions taken
  logic [15:0] g = '0;        // last spacing seen

  // free running timebases, unrelated periods
  always @(posedge clk) begin
    cc <= (cc + 1) % (2 * CHALF);
    sc <= (sc + 1) % (2 * SHALF);
  end
  assign conv_timebase   = (cc >= CHALF);
  assign sample_timebase = (sc >= SHALF);

  // one conversion per start pulse
  always @(posedge clk) begin
    since <= since + 16'h0001;
    if (converter_start_pulse) begin
      n     <= n + 16'h0001;
      g     <= since + 16'h0001;
      since <= '0;
    end
  end
  assign conv_count = n;
  assign conv_gap   = g;
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the convert and trigger timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  actt_pkg::actt_cfg_s cfg = '0;
  logic [15:1]         srcs = '0;   // terminal trigger levels
  logic                sw_st = 1'b0;
  logic                sw_rf = 1'b0;
  logic                smp = 1'b0;  // sample clock
  logic [7:0]          osel = '0;
  logic                csp, st, rt, scs, done, ctb, stb;
  actt_pkg::actt_stat_s stat;
  actt_pkg::actt_term_s term;
  logic [15:0]         n_conv, gap;
  int                  errors = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  int                  scs_n = 0;   // counter start pulses seen

  actt_convert_trigger actt_convert_trigger_i (
    .clk(clk), .srst(srst), .cfg(cfg), .trig_sources(srcs),
    .sw_start_pulse(sw_st), .sw_ref_pulse(sw_rf), .conv_timebase(ctb),
    .sample_timebase(stb), .sample_clock(smp), .out_sel(osel),
    .converter_start_pulse(csp), .start_trigger(st), .ref_trigger(rt),
    .sample_counter_start(scs), .acq_done(done), .status(stat),
    .exported_output_terminal(term));
  actt_adc_model actt_adc_model_i (
    .clk(clk), .converter_start_pulse(csp), .conv_timebase(ctb),
    .sample_timebase(stb), .conv_count(n_conv), .conv_gap(gap));

  initial forever #2.5 clk = ~clk;

  // cycle ceiling and pulse tally
  always @(posedge clk) begin
    cyc++;
    if (scs) scs_n++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bounded wait for one status event
  task automatic expect_ev(input int k);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 400 && !hit; i++) begin
      @(posedge clk);
      #1;
      case (k)
        0: hit = st;
        1: hit = stat.running;
        2: hit = stat.post_counting;
        default: hit = done;
      endcase
    end
    chk(hit, 1'b1);
  endtask

  // drive one trigger source, selector 0 is software
  task automatic src(input logic [3:0] s, input logic r, input logic v);
    @(posedge clk);
    if (s == 4'h0 && r) sw_rf <= v;
    else if (s == 4'h0) sw_st <= v;
    else srcs[s] <= v;
  endtask

  task automatic smp_pulse();
    @(posedge clk);
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
  endtask

  // one whole acquisition from start to done
  task automatic acquire(input logic ext, input logic [3:0] ss,
                         input logic [3:0] rs, input logic [23:0] post,
                         input logic [15:0] gexp);
    logic [15:0] c0;
    int          s0;
    @(posedge clk);
    cfg <= '{ext, 1'b1, ss, rs, 16'h0002, post};
    s0 = scs_n;
    src(ss, 1'b0, 1'b1);
    expect_ev(0);
    chk(stat.armed, 1'b1);
    repeat (12) @(posedge clk);
    src(ss, 1'b0, 1'b0);
    #1;
    chk(stat.sample_ready, 1'b1);
    chk(scs_n - s0, 32'h1);
    smp_pulse();
    expect_ev(1);
    repeat (40) @(posedge clk);
    #1;
    chk(gap, gexp);
    src(rs, 1'b1, 1'b1);
    expect_ev(2);
    chk(rt, 1'b1);
    // a conversion issued on the accepting tick belongs to the run
    @(posedge clk);
    #1;
    c0 = n_conv;
    expect_ev(3);
    repeat (2) @(posedge clk);
    #1;
    chk(n_conv - c0, {8'h00, post[15:0]} );
    chk(stat.running | stat.post_counting, 1'b0);
    src(rs, 1'b1, 1'b0);
    $display("test done ext %0d", ext);
  endtask

  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk({csp, st, rt, scs, done, stat}, '0);
    osel <= 8'he4;
    smp_pulse();
    repeat (3) @(posedge clk);
    #1;
    chk(stat.running, 1'b0);
    chk(term.oe, 4'he);
    $display("test done reset and refusal");
    acquire(1'b0, 4'h0, 4'h0, 24'h000001, 16'h0008);
    acquire(1'b1, 4'h3, 4'h5, 24'h000002, 16'h0004);
    complete_run();
  end
endmodule
`default_nettype wire
